/* bench/nvm_ctrl_asserts.sv */
`timescale 1ns/1ns
module nvm_ctrl_asserts #(
	parameter bit HAS_EEPROM = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic cpuStall,
	input wire logic [7:0] targetPage,
	input wire logic [3:0] activeKind,
	input wire logic [5:0] activeOp,
	input wire logic opActive
);
	wire logic ctrlWr;
	wire logic ctrlRd;
	wire logic keyRd;
	assign ctrlWr = psel && penable && pready && pwrite && paddr == 12'h000;
	assign ctrlRd = psel && !penable && !pwrite && paddr == 12'h000;
	assign keyRd = psel && !penable && !pwrite && paddr == 12'h004;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ************************************************************
	// assertions
	// ************************************************************
	ctrl_unused_a: assert property (ctrlRd |=> prdata[11:7] == 5'h00
		&& prdata[31:16] == 16'h0000) else $error("unused bits set");
	pgm_only_a: assert property (ctrlRd && !HAS_EEPROM |=> !prdata[12])
		else $error("program-only bit without eeprom");
	key_zero_a: assert property (keyRd |=> prdata == 32'h00000000)
		else $error("key register readable");
	launch_cause_a: assert property ($rose(opActive) |-> $past(ctrlWr)
		|| $past(ctrlWr, 2) || $past(ctrlWr, 3)) else $error("launch no write");
	row_stall_a: assert property (opActive && activeKind inside {4'h1,
		4'h2} |-> cpuStall) else $error("row op without stall");
	stall_op_a: assert property (cpuStall |-> opActive)
		else $error("stall while idle");
	kind_set_a: assert property (opActive |-> activeKind != 4'h0)
		else $error("active with no kind");
	row_code_a: assert property (opActive && activeKind == 4'h1 |->
		activeOp inside {6'h18, 6'h19, 6'h1A}) else $error("row erase code");
	prog_code_a: assert property (opActive && activeKind == 4'h2 |->
		activeOp[5:2] == 4'h1) else $error("row program code");
	target_hold_a: assert property (opActive && $past(opActive) |->
		$stable(targetPage) && $stable(activeOp)) else $error("target moved");
	cover property ($rose(opActive));
	cover property (opActive && activeKind == 4'h3);
	cover property (opActive && activeKind == 4'h2);
endmodule
bind nvm_program_erase_control nvm_ctrl_asserts #(
	.HAS_EEPROM(HAS_EEPROM)
) chk (
	.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.cpuStall(cpuStall), .targetPage(targetPage),
	.activeKind(activeKind), .activeOp(activeOp), .opActive(opActive)
);

/* bench/tb.sv */
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic serialModeIn = 1'b0;
	logic resetAbortIn = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, cpuStall, opActive;
	logic [7:0] targetPage;
	logic [15:0] targetOffset;
	logic [3:0] activeKind;
	logic [5:0] activeOp;
	logic [31:0] rd;
	logic err;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	nvm_program_erase_control dut (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serialModeIn(serialModeIn), .resetAbortIn(resetAbortIn),
		.cpuStall(cpuStall), .targetPage(targetPage),
		.targetOffset(targetOffset), .activeKind(activeKind),
		.activeOp(activeOp), .opActive(opActive));
	task conclude;
		$display("counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			errors++;
			conclude();
		end
	end
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task ctl(input logic [31:0] d);
		apb(1'b1, nvm_ctrl_pkg::ADDR_CONTROL, d);
	endtask
	task key(input logic [7:0] k);
		apb(1'b1, nvm_ctrl_pkg::ADDR_KEY, {24'h000000, k});
	endtask
	task unlock;
		key(nvm_ctrl_pkg::KEY_FIRST);
		key(nvm_ctrl_pkg::KEY_SECOND);
	endtask
	task refused;
		repeat (3) @(posedge clk);
		chk("opActive", 32'h0, {31'h0, opActive});
		apb(1'b0, nvm_ctrl_pkg::ADDR_CONTROL, 32'h0);
		chk("startErr", 32'h2000, rd & 32'hA000);
		ctl(32'h4058);
	endtask
	task run(input logic [6:0] cmd, input logic [3:0] kind);
		unlock();
		ctl({16'h0000, 9'h180, cmd});
		repeat (3) @(posedge clk);
		chk("activeKind", {28'h0, kind}, {28'h0, activeKind});
		chk("opActive", {31'h0, kind != 4'h0}, {31'h0, opActive});
		if (kind != 4'h0) begin
			chk("cpuStall", {31'h0, cmd != 7'h50}, {31'h0, cpuStall});
			chk("activeOp", {26'h0, cmd[5:0]}, {26'h0, activeOp});
			chk("targetPage", 32'h12, {24'h0, targetPage});
			chk("targetOffset", 32'h3456, {16'h0, targetOffset});
			while (opActive === 1'b1) @(posedge clk);
		end
		apb(1'b0, nvm_ctrl_pkg::ADDR_CONTROL, 32'h0);
		chk("startErr", 32'h0, rd & 32'hA000);
	endtask
	task test_reset;
		apb(1'b0, nvm_ctrl_pkg::ADDR_CONTROL, 32'h0);
		chk("control", 32'h0, rd);
		apb(1'b0, nvm_ctrl_pkg::ADDR_OP_TIME, 32'h0);
		chk("opTime", {16'h0, nvm_ctrl_pkg::OP_TIME_RESET}, rd);
		apb(1'b1, 12'h020, 32'hFFFFFFFF);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b0, nvm_ctrl_pkg::ADDR_KEY, 32'h0);
		chk("key", 32'h0, rd);
		$display("test reset done");
	endtask
	task test_codes;
		logic [6:0] cmds [11];
		logic [3:0] kinds [11];
		cmds = '{7'h58, 7'h59, 7'h5A, 7'h54, 7'h50, 7'h4C, 7'h04, 7'h68,
			7'h3F, 7'h44, 7'h18};
		kinds = '{4'h1, 4'h1, 4'h1, 4'h3, 4'h3, 4'h3, 4'h2, 4'h0, 4'h0,
			4'h0, 4'h0};
		apb(1'b1, nvm_ctrl_pkg::ADDR_OP_TIME, 32'h8);
		// holding buffers lie outside this block
		apb(1'b1, nvm_ctrl_pkg::ADDR_TABLE_PAGE, 32'h12);
		apb(1'b1, nvm_ctrl_pkg::ADDR_TABLE_OFFSET, 32'h3456);
		for (int i = 0; i < 11; i++) begin
			run(cmds[i], kinds[i]);
		end
		serialModeIn <= 1'b1;
		repeat (4) @(posedge clk);
		run(7'h68, 4'h3);
		run(7'h64, 4'h3);
		serialModeIn <= 1'b0;
		$display("test codes done");
	endtask
	task test_refuse;
		ctl(32'hCFD8);
		apb(1'b0, nvm_ctrl_pkg::ADDR_CONTROL, 32'h0);
		chk("control", 32'h6058, rd);
		ctl(32'h4058);
		key(8'h55);
		apb(1'b1, nvm_ctrl_pkg::ADDR_TABLE_PAGE, 32'h12);
		key(8'hAA);
		ctl(32'hC058);
		refused();
		unlock();
		apb(1'b0, nvm_ctrl_pkg::ADDR_STATUS, 32'h0);
		ctl(32'hC058);
		refused();
		unlock();
		ctl(32'h8058);
		refused();
		key(8'hAA);
		key(8'h55);
		ctl(32'hC058);
		refused();
		$display("test refuse done");
	endtask
	task test_abort;
		apb(1'b1, nvm_ctrl_pkg::ADDR_OP_TIME, 32'h28);
		unlock();
		ctl(32'hC058);
		repeat (3) @(posedge clk);
		chk("opActive", 32'h1, {31'h0, opActive});
		resetAbortIn <= 1'b1;
		repeat (4) @(posedge clk);
		resetAbortIn <= 1'b0;
		while (opActive === 1'b1) @(posedge clk);
		apb(1'b0, nvm_ctrl_pkg::ADDR_CONTROL, 32'h0);
		chk("startErr", 32'h2000, rd & 32'hA000);
		$display("test abort done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		test_reset();
		test_codes();
		test_refuse();
		test_abort();
		conclude();
	end
endmodule

/* common/nvm_ctrl_pkg.sv */
package nvm_ctrl_pkg;
	// ************************************************************
	// register map (byte addresses on the register bus)
	// ************************************************************
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_KEY = 12'h004;
	localparam logic [11:0] ADDR_TABLE_PAGE = 12'h008;
	localparam logic [11:0] ADDR_TABLE_OFFSET = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_OP_TIME = 12'h014;

	// ************************************************************
	// control register fields
	// ************************************************************
	localparam int BIT_START = 15;
	localparam int BIT_WRITE_ENABLE = 14;
	localparam int BIT_SEQ_ERROR = 13;
	localparam int BIT_PROGRAM_ONLY = 12;
	localparam int BIT_ERASE_SELECT = 6;
	localparam int OP_MSB = 5;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK = 16'h707F;

	// ************************************************************
	// unlock keys
	// ************************************************************
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// ************************************************************
	// command codes
	// ************************************************************
	localparam logic [5:0] OP_ERASE_4ROW = 6'h1A;
	localparam logic [5:0] OP_ERASE_2ROW = 6'h19;
	localparam logic [5:0] OP_ERASE_1ROW = 6'h18;
	localparam logic [3:0] OP_ERASE_BOOT = 4'hA;
	localparam logic [3:0] OP_ERASE_ALL = 4'h9;
	localparam logic [3:0] OP_ERASE_CONFIG = 4'h5;
	localparam logic [3:0] OP_ERASE_EEPROM = 4'h4;
	localparam logic [3:0] OP_ERASE_GENERAL = 4'h3;
	localparam logic [3:0] OP_PROGRAM_ROW = 4'h1;

	typedef enum logic [3:0] {
		KIND_NONE = 4'h0,
		KIND_ROW_ERASE = 4'h1,
		KIND_ROW_PROGRAM = 4'h2,
		KIND_BLOCK_ERASE = 4'h3
	} op_kind_t;

	// ************************************************************
	// timing: default self-timed duration
	// ************************************************************
	localparam int CLOCK_MHZ = 20;
	localparam int OP_TIME_US = 100;
	localparam int OP_CYCLES = OP_TIME_US * CLOCK_MHZ;
	localparam logic [15:0] OP_TIME_RESET = 16'(OP_CYCLES);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} seq_state_t;
endpackage

/* core/nvm_program_erase_control.sv */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module nvm_program_erase_control #(
	parameter bit HAS_EEPROM = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serialModeIn,
	input wire logic resetAbortIn,
	output logic cpuStall,
	output logic [7:0] targetPage,
	output logic [15:0] targetOffset,
	output logic [3:0] activeKind,
	output logic [5:0] activeOp,
	output logic opActive
);
	// ************************************************************
	// bus decode
	// ************************************************************
	wire access = psel && penable;
	wire wrAcc = access && pwrite;
	wire selCtl = (paddr == nvm_ctrl_pkg::ADDR_CONTROL);
	wire selKey = (paddr == nvm_ctrl_pkg::ADDR_KEY);
	wire selPage = (paddr == nvm_ctrl_pkg::ADDR_TABLE_PAGE);
	wire selOff = (paddr == nvm_ctrl_pkg::ADDR_TABLE_OFFSET);
	wire selStat = (paddr == nvm_ctrl_pkg::ADDR_STATUS);
	wire selTime = (paddr == nvm_ctrl_pkg::ADDR_OP_TIME);
	wire mapped = selCtl | selKey | selPage | selOff | selStat | selTime;
	wire [7:0] keyByte = pwdata[7:0];

	// ************************************************************
	// registers and synchronisers
	// ************************************************************
	logic [15:0] nvmControl;
	logic [7:0] tablePage;
	logic [15:0] tableOffset;
	logic [15:0] opTime;
	logic firstKeySeen;
	logic unlockWindow;
	logic [1:0] serialSync;
	logic [1:0] abortSync;
	nvm_ctrl_pkg::seq_state_t state;
	nvm_ctrl_pkg::seq_state_t next_state;

	wire serialMode = serialSync[1];
	wire abortReq = abortSync[1];
	wire startBit = nvmControl[nvm_ctrl_pkg::BIT_START];

	// ************************************************************
	// command decode
	// ************************************************************
	wire [15:0] wdat = pwdata[15:0];
	wire ctlWrite = wrAcc && selCtl;
	wire [5:0] newOp = wdat[nvm_ctrl_pkg::OP_MSB:0];
	wire [3:0] newHi = newOp[5:2];
	wire newErase = wdat[nvm_ctrl_pkg::BIT_ERASE_SELECT];
	wire newWren = wdat[nvm_ctrl_pkg::BIT_WRITE_ENABLE];
	// set attempt while busy is ignored
	wire startReq = ctlWrite && wdat[nvm_ctrl_pkg::BIT_START] && !startBit;

	wire isRowErase = newErase && ((newOp == nvm_ctrl_pkg::OP_ERASE_4ROW) ||
		(newOp == nvm_ctrl_pkg::OP_ERASE_2ROW) ||
		(newOp == nvm_ctrl_pkg::OP_ERASE_1ROW));
	wire isBlockErase = newErase && ((newHi == nvm_ctrl_pkg::OP_ERASE_CONFIG) ||
		(newHi == nvm_ctrl_pkg::OP_ERASE_GENERAL) ||
		((newHi == nvm_ctrl_pkg::OP_ERASE_EEPROM) && HAS_EEPROM));
	wire isSerialErase = newErase && serialMode &&
		((newHi == nvm_ctrl_pkg::OP_ERASE_BOOT) ||
		(newHi == nvm_ctrl_pkg::OP_ERASE_ALL));
	wire isRowProg = !newErase && (newHi == nvm_ctrl_pkg::OP_PROGRAM_ROW);
	wire isValidOp = isRowErase | isBlockErase | isSerialErase | isRowProg;
	wire seqOk = unlockWindow && newWren;
	wire launch = startReq && seqOk && isValidOp && (state == nvm_ctrl_pkg::ST_IDLE);
	wire badStart = startReq && !seqOk;
	wire [3:0] newKind = isRowErase ? 4'(nvm_ctrl_pkg::KIND_ROW_ERASE) :
		isRowProg ? 4'(nvm_ctrl_pkg::KIND_ROW_PROGRAM) :
		(isBlockErase | isSerialErase) ?
		4'(nvm_ctrl_pkg::KIND_BLOCK_ERASE) : 4'(nvm_ctrl_pkg::KIND_NONE);

	// ************************************************************
	// operation timer
	// ************************************************************
	logic timerRunning;
	logic timerDone;
	// duration register sets the self-timed length
	op_timer u_timer (
		.clk(clk),
		.rstn(rstn),
		.launch(launch),
		.abort(abortReq),
		.duration(opTime),
		.running(timerRunning),
		.finished(timerDone)
	);

	always_comb begin
		next_state = state;
		case (state)
			nvm_ctrl_pkg::ST_IDLE: begin
				if (launch) begin
					next_state = nvm_ctrl_pkg::ST_BUSY;
				end
			end
			nvm_ctrl_pkg::ST_BUSY: begin
				if (abortReq || timerDone) begin
					next_state = nvm_ctrl_pkg::ST_DONE;
				end
			end
			nvm_ctrl_pkg::ST_DONE: begin
				next_state = nvm_ctrl_pkg::ST_IDLE;
			end
			default: begin
				next_state = nvm_ctrl_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= nvm_ctrl_pkg::ST_IDLE;
			serialSync <= 2'b00;
			abortSync <= 2'b00;
		end else begin
			state <= next_state;
			serialSync <= {serialSync[0], serialModeIn};
			abortSync <= {abortSync[0], resetAbortIn};
		end
	end

	// ************************************************************
	// unlock sequence
	// ************************************************************
	// key writes only move the unlock state
	wire keyWrite = wrAcc && selKey;
	wire key1 = keyWrite && (keyByte == nvm_ctrl_pkg::KEY_FIRST);
	wire key2 = keyWrite && (keyByte == nvm_ctrl_pkg::KEY_SECOND) && firstKeySeen;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			firstKeySeen <= 1'b0;
			unlockWindow <= 1'b0;
		end else begin
			// any other write drops partial unlock
			if (wrAcc) begin
				firstKeySeen <= key1;
			end
			// window closes after next bus transfer
			if (key2) begin
				unlockWindow <= 1'b1;
			end else if (access) begin
				unlockWindow <= 1'b0;
			end
		end
	end

	// ************************************************************
	// control register
	// ************************************************************
	wire [15:0] keptBits = nvmControl & ~nvm_ctrl_pkg::CONTROL_WMASK;
	wire [15:0] swBits = wdat & nvm_ctrl_pkg::CONTROL_WMASK;
	// program-only bit exists with eeprom only
	wire [15:0] pgmMask = HAS_EEPROM ? 16'hFFFF : 16'hEFFF;
	wire [15:0] ctlWritten = (keptBits | swBits) & pgmMask;
	wire errKeep = nvmControl[nvm_ctrl_pkg::BIT_SEQ_ERROR];
	// abort and timer end share one exit
	wire opEnd = (state == nvm_ctrl_pkg::ST_BUSY) && (abortReq || timerDone);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nvmControl <= nvm_ctrl_pkg::CONTROL_RESET;
		end else begin
			if (ctlWrite) begin
				nvmControl <= ctlWritten;
				// software cannot clear the start bit
				nvmControl[nvm_ctrl_pkg::BIT_START] <= startBit | launch;
				// error set wins over software clear
				nvmControl[nvm_ctrl_pkg::BIT_SEQ_ERROR] <= badStart |
					(ctlWritten[nvm_ctrl_pkg::BIT_SEQ_ERROR] && errKeep);
			end
			if (opEnd) begin
				nvmControl[nvm_ctrl_pkg::BIT_START] <= 1'b0;
			end
			if (opEnd && abortReq) begin
				nvmControl[nvm_ctrl_pkg::BIT_SEQ_ERROR] <= 1'b1;
			end
		end
	end

	// ************************************************************
	// table pointer, timing and outputs
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tablePage <= 8'h00;
			tableOffset <= 16'h0000;
			opTime <= nvm_ctrl_pkg::OP_TIME_RESET;
		end else begin
			if (wrAcc && selPage) begin
				tablePage <= pwdata[7:0];
			end
			if (wrAcc && selOff) begin
				tableOffset <= wdat;
			end
			if (wrAcc && selTime && !startBit) begin
				opTime <= wdat;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpuStall <= 1'b0;
			targetPage <= 8'h00;
			targetOffset <= 16'h0000;
			activeKind <= 4'(nvm_ctrl_pkg::KIND_NONE);
			activeOp <= 6'h00;
			opActive <= 1'b0;
		end else begin
			// latch row address from table pointer
			if (launch) begin
				targetPage <= tablePage;
				targetOffset <= tableOffset;
				activeKind <= newKind;
				activeOp <= newOp;
			end else if (opEnd) begin
				activeKind <= 4'(nvm_ctrl_pkg::KIND_NONE);
			end
			opActive <= launch | (opActive && !opEnd);
			// stall for flash work, not eeprom
			if (launch) begin
				cpuStall <= !(newErase && newHi == nvm_ctrl_pkg::OP_ERASE_EEPROM);
			end else if (opEnd) begin
				cpuStall <= 1'b0;
			end
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	wire [15:0] statusWord = {13'h0000, timerRunning, serialMode, opActive};
	wire [31:0] readMux = selKey ? 32'h00000000 :
		selCtl ? {16'h0000, nvmControl} :
		selPage ? {24'h000000, tablePage} :
		selOff ? {16'h0000, tableOffset} :
		selStat ? {16'h0000, statusWord} :
		selTime ? {16'h0000, opTime} : 32'h00000000;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// one wait-free access after every setup
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? readMux : 32'h00000000;
		end
	end
endmodule

/* core/op_timer.sv */
`timescale 1ns/1ns
// ************************************************************
// self-timed operation counter
// ************************************************************
module op_timer (
	input wire logic clk,
	input wire logic rstn,
	input wire logic launch,
	input wire logic abort,
	input wire logic [15:0] duration,
	output logic running,
	output logic finished
);
	logic [15:0] remain;
	wire lastTick = running && (remain <= 16'h0001);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			remain <= 16'h0000;
			running <= 1'b0;
			finished <= 1'b0;
		end else begin
			finished <= lastTick && !abort;
			if (abort) begin
				running <= 1'b0;
				remain <= 16'h0000;
			end else if (launch && !running) begin
				running <= 1'b1;
				remain <= (duration == 16'h0000) ? 16'h0001 : duration;
			end else if (running) begin
				remain <= remain - 16'h0001;
				if (lastTick) begin
					running <= 1'b0;
				end
			end
		end
	end
endmodule
